// >>> core/ucc_pkg.sv
// Package of constants and types for the serial port control block
// Notes on behaviour
// - Enable sets port, tx, rx and FIFOs
// - Disable clears enables, drains character, flushes FIFO
// - Infrared mode enable selects infrared line coding
// - Separate infrared low-power bit
// - Infrared disable clears both infrared bits
// - FIFOs switch off/on together; off holds one
// - Tx/rx thresholds: 1/8,2/8,4/8,6/8,7/8
// - Threshold settings read back as written
// - Eleven interrupt sources
// - Per-source mask set or cleared individually
// - Only unmasked sources reach interrupt output
// - Cleared source stays off until retriggered
// - Raw and masked status views, same layout
// - Separate tx and rx DMA request enables
// - Stop rx DMA requests on receive error
package ucc_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int IRQ_W   = 11;
    localparam int LVL_W   = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W   = 5;

    // ************************************************************
    // Interrupt bit positions
    // ************************************************************
    localparam int IRQ_OVERRUN     = 0;
    localparam int IRQ_BREAK       = 1;
    localparam int IRQ_PARITY      = 2;
    localparam int IRQ_FRAMING     = 3;
    localparam int IRQ_RX_TIMEOUT  = 4;
    localparam int IRQ_TX          = 5;
    localparam int IRQ_RX          = 6;
    localparam int IRQ_DATA_SET    = 7;
    localparam int IRQ_CARRIER     = 8;
    localparam int IRQ_CLEAR_SEND  = 9;
    localparam int IRQ_RING        = 10;

    // ************************************************************
    // Threshold encodings
    // ************************************************************
    localparam logic [LVL_W-1:0] LVL_ONE_EIGHTH    = 3'h0;
    localparam logic [LVL_W-1:0] LVL_TWO_EIGHTHS   = 3'h1;
    localparam logic [LVL_W-1:0] LVL_FOUR_EIGHTHS  = 3'h2;
    localparam logic [LVL_W-1:0] LVL_SIX_EIGHTHS   = 3'h3;
    localparam logic [LVL_W-1:0] LVL_SEVEN_EIGHTHS = 3'h4;
    localparam logic [LVL_W-1:0] LVL_RESET         = LVL_FOUR_EIGHTHS;

    localparam logic [IRQ_W-1:0] IRQ_NONE = 11'h000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;

    // Disable sequence states
    typedef enum logic [1:0] {
        UCC_RUN,
        UCC_DRAIN,
        UCC_FLUSH
    } ucc_dis_t;

endpackage

// >>> core/ucc_level.sv
// Threshold comparator for one FIFO direction
`timescale 1ns/1ps
`default_nettype none
module ucc_level
    import ucc_pkg::*;
#(
    parameter bit FALLING = 1'b0
) (
    // Settings and level
    input  wire logic [LVL_W-1:0] sel,
    input  wire logic             fifo_on,
    input  wire logic [CNT_W-1:0] fill,
    // Result
    output logic                  hit
);
    logic [CNT_W-1:0] mark;

    // Eighths of the depth; an unknown code falls back to half
    always_comb begin
        case (sel)
            LVL_ONE_EIGHTH:    mark = CNT_W'(FIFO_DEPTH / 8);
            LVL_TWO_EIGHTHS:   mark = CNT_W'(FIFO_DEPTH * 2 / 8);
            LVL_SIX_EIGHTHS:   mark = CNT_W'(FIFO_DEPTH * 6 / 8);
            LVL_SEVEN_EIGHTHS: mark = CNT_W'(FIFO_DEPTH * 7 / 8);
            default:           mark = CNT_W'(FIFO_DEPTH * 4 / 8);
        endcase
    end

    // With FIFOs off the single holding slot sets the level
    always_comb begin
        if (!fifo_on) begin
            hit = FALLING ? (fill == CNT_ZERO) : (fill != CNT_ZERO);
        end else if (FALLING) begin
            hit = (fill <= mark);
        end else begin
            hit = (fill >= mark);
        end
    end
endmodule
`default_nettype wire

// >>> core/ucc_ctrl.sv
// Control, interrupt and DMA request logic of the serial port
`timescale 1ns/1ps
`default_nettype none
module ucc_ctrl
    import ucc_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Port enable commands
    input  wire logic             enable_cmd,
    input  wire logic             disable_cmd,
    input  wire logic             tx_busy,
    output logic                  port_enable,
    output logic                  transmitter_enable,
    output logic                  receiver_enable,
    output logic                  tx_fifo_flush,
    output logic                  disable_busy,
    // Infrared controls
    input  wire logic             ir_enable_cmd,
    input  wire logic             ir_low_power_req,
    input  wire logic             ir_disable_cmd,
    output logic                  infrared_mode_enable,
    output logic                  infrared_low_power,
    // FIFO controls
    input  wire logic             fifo_enable_cmd,
    input  wire logic             fifo_disable_cmd,
    output logic                  fifo_enable,
    output logic [CNT_W-1:0]      fifo_limit,
    // Thresholds
    input  wire logic             level_write,
    input  wire logic [LVL_W-1:0] tx_level_in,
    input  wire logic [LVL_W-1:0] rx_level_in,
    output logic [LVL_W-1:0]      tx_level,
    output logic [LVL_W-1:0]      rx_level,
    // FIFO fill levels from the datapath
    input  wire logic [CNT_W-1:0] tx_fill,
    input  wire logic [CNT_W-1:0] rx_fill,
    // Event pulses from the datapath and modem lines
    input  wire logic [IRQ_W-1:0] event_in,
    // Interrupt mask and clear
    input  wire logic [IRQ_W-1:0] mask_set,
    input  wire logic [IRQ_W-1:0] mask_clr,
    input  wire logic [IRQ_W-1:0] irq_clear,
    output logic [IRQ_W-1:0]      irq_mask,
    output logic [IRQ_W-1:0]      raw_status,
    output logic [IRQ_W-1:0]      masked_status,
    output logic                  irq,
    // DMA
    input  wire logic             dma_tx_set,
    input  wire logic             dma_tx_clr,
    input  wire logic             dma_rx_set,
    input  wire logic             dma_rx_clr,
    input  wire logic             dma_stop_set,
    input  wire logic             dma_stop_clr,
    output logic                  dma_tx_enable,
    output logic                  dma_rx_enable,
    output logic                  dma_stop_on_rx_error,
    output logic                  dma_rx_halted,
    output logic                  dma_tx_req,
    output logic                  dma_rx_req
);

    // ************************************************************
    // Port enable and disable sequence
    // ************************************************************
    ucc_dis_t dis_q;
    logic     rx_err;
    logic     tx_hit;
    logic     rx_hit;
    logic [IRQ_W-1:0] set_vec;

    // Disable drops enables at once, then drains and flushes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_enable        <= 1'b0;
            transmitter_enable <= 1'b0;
            receiver_enable    <= 1'b0;
        end else if (disable_cmd) begin
            port_enable        <= 1'b0;
            transmitter_enable <= 1'b0;
            receiver_enable    <= 1'b0;
        end else if (enable_cmd && dis_q == UCC_RUN) begin
            port_enable        <= 1'b1;
            transmitter_enable <= 1'b1;
            receiver_enable    <= 1'b1;
        end
    end

    // Drain waits for the shifter to go idle before flushing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dis_q <= UCC_RUN;
        end else begin
            case (dis_q)
                UCC_RUN:   if (disable_cmd) dis_q <= UCC_DRAIN;
                UCC_DRAIN: if (!tx_busy) dis_q <= UCC_FLUSH;
                // A fresh disable during the flush starts a new drain
                UCC_FLUSH: dis_q <= disable_cmd ? UCC_DRAIN : UCC_RUN;
                default:   dis_q <= UCC_RUN;
            endcase
        end
    end

    assign tx_fifo_flush = (dis_q == UCC_FLUSH);
    assign disable_busy  = (dis_q != UCC_RUN);

    // ************************************************************
    // Infrared mode
    // ************************************************************
    // Disable wins, so a disable always clears both bits together
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            infrared_mode_enable <= 1'b0;
            infrared_low_power   <= 1'b0;
        end else if (ir_disable_cmd) begin
            infrared_mode_enable <= 1'b0;
            infrared_low_power   <= 1'b0;
        end else if (ir_enable_cmd) begin
            infrared_mode_enable <= 1'b1;
            infrared_low_power   <= ir_low_power_req;
        end
    end

    // ************************************************************
    // FIFO enable and thresholds
    // ************************************************************
    // Port enable also turns the FIFOs on
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fifo_enable <= 1'b0;
        end else if (fifo_disable_cmd) begin
            fifo_enable <= 1'b0;
        end else if (fifo_enable_cmd ||
                     (enable_cmd && !disable_cmd && dis_q == UCC_RUN)) begin
            fifo_enable <= 1'b1;
        end
    end

    // Capacity seen by the datapath: one slot when FIFOs are off
    assign fifo_limit = fifo_enable ? CNT_W'(FIFO_DEPTH) : CNT_ONE;

    // Settings stored verbatim so reads return the written code
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_level <= LVL_RESET;
            rx_level <= LVL_RESET;
        end else if (level_write) begin
            tx_level <= tx_level_in;
            rx_level <= rx_level_in;
        end
    end

    ucc_level #(.FALLING(1'b1)) u_tx_level (
        .sel     (tx_level),
        .fifo_on (fifo_enable),
        .fill    (tx_fill),
        .hit     (tx_hit)
    );

    ucc_level #(.FALLING(1'b0)) u_rx_level (
        .sel     (rx_level),
        .fifo_on (fifo_enable),
        .fill    (rx_fill),
        .hit     (rx_hit)
    );

    // ************************************************************
    // Interrupts
    // ************************************************************
    // FIFO level crossings feed the tx and rx sources
    always_comb begin
        set_vec          = event_in;
        set_vec[IRQ_TX]  = event_in[IRQ_TX] | (tx_hit & transmitter_enable);
        set_vec[IRQ_RX]  = event_in[IRQ_RX] | (rx_hit & receiver_enable);
    end

    // Set wins over a clear in the same cycle, so no event is lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            raw_status <= IRQ_NONE;
        end else begin
            raw_status <= (raw_status & ~irq_clear) | set_vec;
        end
    end

    // Set has priority over clear for the same mask bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_mask <= IRQ_NONE;
        end else begin
            irq_mask <= (irq_mask & ~mask_clr) | mask_set;
        end
    end

    assign masked_status = raw_status & irq_mask;
    assign irq           = |masked_status;

    // ************************************************************
    // DMA requests
    // ************************************************************
    assign rx_err = |event_in[IRQ_FRAMING:IRQ_OVERRUN];

    // Direction enables; set wins over clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dma_tx_enable        <= 1'b0;
            dma_rx_enable        <= 1'b0;
            dma_stop_on_rx_error <= 1'b0;
        end else begin
            dma_tx_enable <= (dma_tx_enable & ~dma_tx_clr) | dma_tx_set;
            dma_rx_enable <= (dma_rx_enable & ~dma_rx_clr) | dma_rx_set;
            dma_stop_on_rx_error <= (dma_stop_on_rx_error & ~dma_stop_clr)
                                    | dma_stop_set;
        end
    end

    // Halt latches on a receive error until rx DMA is re-armed or stop on rx error is cleared
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dma_rx_halted <= 1'b0;
        end else if (rx_err && dma_stop_on_rx_error) begin
            dma_rx_halted <= 1'b1;
        end else if (dma_rx_set || !dma_stop_on_rx_error) begin
            dma_rx_halted <= 1'b0;
        end
    end

    // Requests follow the FIFO levels in enabled directions only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dma_tx_req <= 1'b0;
            dma_rx_req <= 1'b0;
        end else begin
            dma_tx_req <= dma_tx_enable & transmitter_enable & tx_hit;
            dma_rx_req <= dma_rx_enable & receiver_enable & rx_hit
                          & ~dma_rx_halted
                          & ~(rx_err & dma_stop_on_rx_error);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_irq_masked;
        @(posedge core_clk) disable iff (rst)
        (irq_mask == IRQ_NONE && mask_set == IRQ_NONE) |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt with no enabled source");

    property p_clear;
        @(posedge core_clk) disable iff (rst)
        (irq_clear[IRQ_RING] && !set_vec[IRQ_RING]) |=> !raw_status[IRQ_RING];
    endproperty
    a_clear: assert property (p_clear)
        else $error("cleared source still set");

    property p_set_wins;
        @(posedge core_clk) disable iff (rst)
        event_in[IRQ_OVERRUN] |=> raw_status[IRQ_OVERRUN];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost");

    property p_disable;
        @(posedge core_clk) disable iff (rst)
        disable_cmd |=> !port_enable && !transmitter_enable && disable_busy;
    endproperty
    a_disable: assert property (p_disable)
        else $error("disable did not drop enables");

    property p_flush;
        @(posedge core_clk) disable iff (rst)
        (dis_q == UCC_DRAIN && !tx_busy) |=> tx_fifo_flush ##1 !tx_fifo_flush;
    endproperty
    a_flush: assert property (p_flush)
        else $error("flush not one cycle after drain");

    property p_enable;
        @(posedge core_clk) disable iff (rst)
        (enable_cmd && !disable_cmd && !fifo_disable_cmd && dis_q == UCC_RUN)
        |=> port_enable && receiver_enable && fifo_enable;
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable incomplete");

    property p_ir_off;
        @(posedge core_clk) disable iff (rst)
        ir_disable_cmd |=> !infrared_mode_enable && !infrared_low_power;
    endproperty
    a_ir_off: assert property (p_ir_off)
        else $error("infrared bits not cleared");

    property p_level_rb;
        @(posedge core_clk) disable iff (rst)
        level_write |=> tx_level == $past(tx_level_in)
                        && rx_level == $past(rx_level_in);
    endproperty
    a_level_rb: assert property (p_level_rb)
        else $error("threshold readback differs");

    property p_dma_tx;
        @(posedge core_clk) disable iff (rst)
        !dma_tx_enable |=> !dma_tx_req;
    endproperty
    a_dma_tx: assert property (p_dma_tx)
        else $error("tx request while disabled");

    property p_dma_stop;
        @(posedge core_clk) disable iff (rst)
        (dma_stop_on_rx_error && rx_err && !dma_stop_clr)
        |=> !dma_rx_req [*2];
    endproperty
    a_dma_stop: assert property (p_dma_stop)
        else $error("rx request after error");

endmodule
`default_nettype wire

// >>> tb/ucc_far.sv
// Far-side model: character shifter and modem lines of the serial port
`timescale 1ns/1ps
`default_nettype none
module ucc_far #(
    parameter int BUSY_CYC = 5
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Requests from the bench
    input  wire logic       send,
    input  wire logic [3:0] toggle,
    // Towards the control block
    output logic            tx_busy,
    output logic [3:0]      modem_ev
);
    logic [7:0] cnt_q;
    logic [3:0] line_q;

    // Shifter stays busy for a whole character, never cut short
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (send) begin
            cnt_q <= 8'(BUSY_CYC);
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    assign tx_busy = (cnt_q != 8'h00);

    // Each line flip is reported as a single change pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_q   <= 4'h0;
            modem_ev <= 4'h0;
        end else begin
            line_q   <= line_q ^ toggle;
            modem_ev <= toggle;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module tb
    import ucc_pkg::*;
();
    logic             core_clk, rst, send;
    logic             enable_cmd, disable_cmd, tx_busy, tx_fifo_flush;
    logic             port_enable, transmitter_enable, receiver_enable;
    logic             disable_busy, ir_enable_cmd, ir_disable_cmd;
    logic             ir_low_power_req, infrared_mode_enable;
    logic             infrared_low_power, fifo_enable, level_write;
    logic             fifo_enable_cmd, fifo_disable_cmd, irq;
    logic [CNT_W-1:0] fifo_limit, tx_fill, rx_fill;
    logic [LVL_W-1:0] tx_level_in, rx_level_in, tx_level, rx_level;
    logic [IRQ_W-1:0] event_in, mask_set, mask_clr, irq_clear;
    logic [IRQ_W-1:0] irq_mask, raw_status, masked_status;
    logic             dma_tx_set, dma_tx_clr, dma_rx_set, dma_rx_clr;
    logic             dma_stop_set, dma_stop_clr, dma_tx_enable;
    logic             dma_rx_enable, dma_stop_on_rx_error, dma_rx_halted;
    logic             dma_tx_req, dma_rx_req;
    logic [6:0]       ev;
    logic [3:0]       toggle, modem_ev;
    logic [31:0]      seed;
    logic [IRQ_W-1:0] m;
    int               checks, num_errors, n, rc;

    // Modem change pulses come from the far-side model
    assign event_in = {modem_ev, ev};

    ucc_ctrl u_ucc_ctrl (.core_clk, .rst, .enable_cmd, .disable_cmd,
        .tx_busy, .port_enable, .transmitter_enable, .receiver_enable,
        .tx_fifo_flush, .disable_busy, .ir_enable_cmd, .ir_low_power_req,
        .ir_disable_cmd, .infrared_mode_enable, .infrared_low_power,
        .fifo_enable_cmd, .fifo_disable_cmd, .fifo_enable, .fifo_limit,
        .level_write, .tx_level_in, .rx_level_in, .tx_level, .rx_level,
        .tx_fill, .rx_fill, .event_in, .mask_set, .mask_clr, .irq_clear,
        .irq_mask, .raw_status, .masked_status, .irq, .dma_tx_set,
        .dma_tx_clr, .dma_rx_set, .dma_rx_clr, .dma_stop_set,
        .dma_stop_clr, .dma_tx_enable, .dma_rx_enable,
        .dma_stop_on_rx_error, .dma_rx_halted, .dma_tx_req, .dma_rx_req);

    ucc_far u_ucc_far (.core_clk, .rst, .send, .toggle, .tx_busy,
        .modem_ev);

    // ************************************************************
    // Helpers
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Inputs always move 1 ns after the edge, away from sampling
    task automatic step(input int k = 1);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        step();
        s = 1'b0;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Fill count at which a threshold code trips
    function automatic logic [CNT_W-1:0] mark(input logic [LVL_W-1:0] c);
        int e;
        e = (c == 3'h0) ? 1 : (c == 3'h1) ? 2 : (c == 3'h2) ? 4 :
            (c == 3'h3) ? 6 : 7;
        return CNT_W'(FIFO_DEPTH * e / 8);
    endfunction

    // Modem sources take one extra cycle through the far-side model
    task automatic fire(input int i);
        if (i < 7) begin
            ev[i] = 1'b1;
            step();
            ev = 7'h00;
        end else begin
            toggle[i-7] = 1'b1;
            step();
            toggle = 4'h0;
            step();
        end
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        summarize();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        {send, enable_cmd, disable_cmd, ir_enable_cmd, ir_disable_cmd,
         ir_low_power_req, fifo_enable_cmd, fifo_disable_cmd, level_write,
         tx_level_in, rx_level_in, mask_set, mask_clr, irq_clear,
         dma_tx_set, dma_tx_clr, dma_rx_set, dma_rx_clr, dma_stop_set,
         dma_stop_clr, ev, toggle} = '0;
        tx_fill = 5'h10;
        rx_fill = 5'h00;
        seed = 32'hF22EF325;
        rst = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 rst = 1'b0;
        chk({port_enable, fifo_enable, irq, raw_status}, 16'h0000);
        chk({tx_level, rx_level}, {LVL_RESET, LVL_RESET});
        pulse(enable_cmd);
        chk({port_enable, transmitter_enable, receiver_enable}, 3'h7);
        chk({fifo_enable, fifo_limit}, {1'b1, 5'h10});
        pulse(fifo_disable_cmd);
        chk({fifo_enable, fifo_limit}, {1'b0, CNT_ONE});
        pulse(fifo_enable_cmd);
        chk({fifo_enable, fifo_limit}, {1'b1, 5'h10});
        // Both infrared variants, each followed by the combined disable
        for (int lp = 0; lp < 2; lp++) begin
            ir_low_power_req = lp[0];
            pulse(ir_enable_cmd);
            ir_low_power_req = 1'b0;
            chk({infrared_mode_enable, infrared_low_power},
                {1'b1, lp[0]});
            pulse(ir_disable_cmd);
            chk({infrared_mode_enable, infrared_low_power}, 2'h0);
        end
        // Every non-level source with a random mask
        for (int i = 0; i < IRQ_W; i++) begin
            if (i == IRQ_TX || i == IRQ_RX) continue;
            seed = nx(seed);
            m = seed[IRQ_W-1:0];
            mask_set = m;
            mask_clr = ~m;
            step();
            {mask_set, mask_clr} = '0;
            chk(irq_mask, m);
            fire(i);
            chk(raw_status, IRQ_W'(1) << i);
            chk(masked_status, (IRQ_W'(1) << i) & m);
            chk(irq, m[i]);
            irq_clear = IRQ_W'(1) << i;
            step();
            irq_clear = IRQ_NONE;
            chk({irq, raw_status}, 12'h000);
        end
        // Threshold codes, each just off and just on its trip point
        for (int c = 0; c < 5; c++) begin
            seed = nx(seed);
            rc = int'(seed[7:0]) % 5;
            tx_level_in = LVL_W'(c);
            rx_level_in = LVL_W'(rc);
            pulse(level_write);
            chk({tx_level, rx_level}, {tx_level_in, rx_level_in});
            tx_fill = mark(tx_level_in) + CNT_ONE;
            rx_fill = mark(rx_level_in) - CNT_ONE;
            irq_clear = 11'h060;
            step();
            irq_clear = IRQ_NONE;
            chk(raw_status[6:5], 2'h0);
            tx_fill = mark(tx_level_in);
            rx_fill = mark(rx_level_in);
            step();
            chk(raw_status[6:5], 2'h3);
        end
        // FIFOs off: one slot, so empty tx and one rx character trip
        pulse(fifo_disable_cmd);
        tx_fill = CNT_ONE;
        rx_fill = CNT_ZERO;
        irq_clear = 11'h060;
        step();
        irq_clear = IRQ_NONE;
        chk(raw_status[6:5], 2'h0);
        tx_fill = CNT_ZERO;
        rx_fill = CNT_ONE;
        step();
        chk(raw_status[6:5], 2'h3);
        // Channel is taken as set up before requests are enabled
        dma_tx_set = 1'b1;
        dma_rx_set = 1'b1;
        step();
        {dma_tx_set, dma_rx_set} = 2'h0;
        chk({dma_tx_enable, dma_rx_enable}, 2'h3);
        step();
        chk({dma_tx_req, dma_rx_req}, 2'h3);
        pulse(dma_tx_clr);
        step();
        chk({dma_tx_req, dma_rx_req}, 2'h1);
        pulse(dma_stop_set);
        seed = nx(seed);
        fire(int'(seed[1:0]));
        chk({dma_stop_on_rx_error, dma_rx_halted}, 2'h3);
        step();
        chk(dma_rx_req, 1'b0);
        pulse(dma_rx_set);
        pulse(dma_stop_clr);
        fire(IRQ_FRAMING);
        step();
        chk({dma_rx_halted, dma_rx_req}, 2'h1);
        // Disable while a character is still on the line
        pulse(send);
        pulse(disable_cmd);
        chk({port_enable, transmitter_enable, receiver_enable}, 3'h0);
        chk({disable_busy, tx_fifo_flush}, 2'h2);
        pulse(enable_cmd);
        chk(port_enable, 1'b0);
        n = 0;
        while (tx_fifo_flush !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        chk({tx_fifo_flush, tx_busy}, 2'h2);
        step();
        chk({tx_fifo_flush, disable_busy}, 2'h0);
        step(2);
        summarize();
    end
endmodule
`default_nettype wire
